// File: src/sarseq_pkg.sv
// Purpose: shared constants and types of the converter sequencer
// Assumes: mclk is the selected converter clock, 100 MHz
// Notes:   field encodings are those the sequencer ports expect
package sarseq_pkg;

	// clock figures
	localparam int SARSEQ_CLK_KHZ     = 100000;
	localparam int SARSEQ_SAR_MAX_KHZ = 18000;
	// least divide ratio that keeps the approximation clock at or under its limit
	localparam int SARSEQ_MIN_RATIO   = (SARSEQ_CLK_KHZ + SARSEQ_SAR_MAX_KHZ - 1)
		/ SARSEQ_SAR_MAX_KHZ;
	localparam logic [5:0] SARSEQ_MIN_RATIO_W = 6'(SARSEQ_MIN_RATIO);

	// tail of every conversion cycle, in converter clock periods
	localparam logic [2:0] SARSEQ_FINISH_CYCLES = 3'h4;

	// resolution select: 1 is 12 bits, 0 is 10 bits
	localparam logic       SARSEQ_RES_12      = 1'b1;
	localparam logic [11:0] SARSEQ_MSB_12     = 12'h800;
	localparam logic [11:0] SARSEQ_MSB_10     = 12'h200;

	// trigger modes
	localparam logic [1:0] SARSEQ_TRIG_SOFTWARE = 2'h0;
	localparam logic [1:0] SARSEQ_TRIG_INTERNAL = 2'h1;
	localparam logic [1:0] SARSEQ_TRIG_EXTERNAL = 2'h2;

	// reset values
	localparam logic       SARSEQ_CLKSEL_RESET = 1'b0;
	localparam logic [15:0] SARSEQ_RESULT_RESET = 16'h0000;

	// autoscan output words take two bytes each
	localparam logic [15:0] SARSEQ_WORD_STEP = 16'h0002;

	typedef enum logic [4:0] {
		SARSEQ_IDLE    = 5'h01,
		SARSEQ_POWER   = 5'h02,
		SARSEQ_TRACK   = 5'h04,
		SARSEQ_CONVERT = 5'h08,
		SARSEQ_FINISH  = 5'h10
	} sarseq_state_t;

	typedef enum logic [2:0] {
		SARSEQ_SCAN_OFF  = 3'h1,
		SARSEQ_SCAN_WAIT = 3'h2,
		SARSEQ_SCAN_RUN  = 3'h4
	} sarseq_scan_state_t;

endpackage

// File: src/sarseq_link_if.sv
// Purpose: signals between the sequencer, its divider and its scanner
// Assumes: all on mclk
// Notes:   one modport pair per helper module
`timescale 1ns/1ps
`default_nettype none
interface sarseq_link_if;
	// divider
	logic        div_restart;
	logic [4:0]  div_ratio;
	logic        div_tick;
	// scanner settings and word hand-off
	logic        scan_enable;
	logic        conv_enable;
	logic [4:0]  first_channel;
	logic [1:0]  channel_count;
	logic [15:0] start_address;
	logic [5:0]  word_count;
	logic        word_valid;
	logic [15:0] word_data;
	// scanner state
	logic        scan_active;
	logic        scan_running;
	logic [4:0]  scan_channel;
	logic        scan_done;
	logic        mem_valid;
	logic [15:0] mem_address;
	logic [15:0] mem_data;
	logic [15:0] saved_address;
	logic [4:0]  saved_channel;

	modport div_end (input div_restart, input div_ratio, output div_tick);
	modport scanner (input scan_enable, input conv_enable, input first_channel,
		input channel_count, input start_address, input word_count,
		input word_valid, input word_data, output scan_active, output scan_running,
		output scan_channel, output scan_done, output mem_valid, output mem_address,
		output mem_data, output saved_address, output saved_channel);
	modport seq (output div_restart, output div_ratio, input div_tick,
		output scan_enable, output conv_enable, output first_channel,
		output channel_count, output start_address, output word_count,
		output word_valid, output word_data, input scan_active, input scan_running,
		input scan_channel, input scan_done, input mem_valid, input mem_address,
		input mem_data, input saved_address, input saved_channel);
endinterface
`default_nettype wire

// File: src/sarseq_divider.sv
// Purpose: approximation clock timebase, one tick per divide period
// Assumes: ratio field n divides by n+1
// Notes:   restart realigns the period to the start of a cycle
`timescale 1ns/1ps
`default_nettype none
module sarseq_divider
	import sarseq_pkg::*;
(
	// clock and reset
	input  wire logic   mclk,
	input  wire logic   rst_n,
	// link to the sequencer
	sarseq_link_if.div_end lnk
);

	logic [4:0] count;

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			count <= 5'h00;
		else if (lnk.div_restart || count == lnk.div_ratio)
			count <= 5'h00;
		else
			count <= count + 5'h01;
	end

	assign lnk.div_tick = !lnk.div_restart && count == lnk.div_ratio;

endmodule
`default_nettype wire

// File: src/sarseq_scanner.sv
// Purpose: autoscan engine, channel stepping and result word placement
// Assumes: memory accepts every write in the cycle it is offered
// Notes:   settings are latched on entry and on each reload
`timescale 1ns/1ps
`default_nettype none
module sarseq_scanner
	import sarseq_pkg::*;
(
	// clock and reset
	input  wire logic   mclk,
	input  wire logic   rst_n,
	// link to the sequencer
	sarseq_link_if.scanner lnk
);

	sarseq_scan_state_t state;
	logic [15:0] address;
	logic [5:0]  words_left;
	logic [4:0]  first;
	logic [1:0]  last_index;
	logic [1:0]  index;
	logic        done;
	logic        load;
	logic        last_word;

	assign load      = lnk.conv_enable && lnk.scan_enable
		&& (state == SARSEQ_SCAN_OFF || (lnk.word_valid && last_word));
	assign last_word = words_left == 6'h00;

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			state <= SARSEQ_SCAN_OFF;
		else if (!lnk.conv_enable)
			state <= SARSEQ_SCAN_OFF;
		else if (load)
			state <= SARSEQ_SCAN_WAIT;
		else if (lnk.word_valid && state != SARSEQ_SCAN_OFF)
			state <= last_word ? SARSEQ_SCAN_OFF : SARSEQ_SCAN_RUN;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			address    <= 16'h0000;
			words_left <= 6'h00;
			first      <= 5'h00;
			last_index <= 2'h0;
			index      <= 2'h0;
		end
		else if (load)
		begin
			// starting address is kept even
			address    <= {lnk.start_address[15:1], 1'b0};
			words_left <= lnk.word_count;
			first      <= lnk.first_channel;
			last_index <= lnk.channel_count;
			index      <= 2'h0;
		end
		else if (lnk.word_valid && state != SARSEQ_SCAN_OFF)
		begin
			address    <= address + SARSEQ_WORD_STEP;
			words_left <= words_left - 6'h01;
			index      <= (index == last_index) ? 2'h0 : index + 2'h1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lnk.mem_valid     <= 1'b0;
			lnk.mem_address   <= 16'h0000;
			lnk.mem_data      <= 16'h0000;
			done              <= 1'b0;
			lnk.saved_address <= 16'h0000;
			lnk.saved_channel <= 5'h00;
		end
		else
		begin
			lnk.mem_valid   <= lnk.word_valid && state != SARSEQ_SCAN_OFF;
			lnk.mem_address <= address;
			lnk.mem_data    <= lnk.word_data;
			done            <= lnk.word_valid && state != SARSEQ_SCAN_OFF && last_word;
			if (lnk.word_valid && state != SARSEQ_SCAN_OFF && last_word)
			begin
				lnk.saved_address <= address + SARSEQ_WORD_STEP;
				lnk.saved_channel <= lnk.scan_channel;
			end
		end
	end

	assign lnk.scan_done    = done;
	assign lnk.scan_active  = state != SARSEQ_SCAN_OFF;
	assign lnk.scan_running = state == SARSEQ_SCAN_RUN;
	assign lnk.scan_channel = first + {3'h0, index};

endmodule
`default_nettype wire

// File: src/sarseq_top.sv
// Purpose: successive-approximation converter sequencer
// Assumes: mclk is the converter clock picked outside by a glitch-free mux
// Notes:   phases count approximation clock ticks; tail counts mclk cycles
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Converter clock is system clock by default, or the fast oscillator.
// - Approximation clock is the converter clock divided by the divider field plus one.
// - Power-off mode: power up once, run all repeats, then power down.
// - Without power-off mode no power-up phase; converter stays powered.
// - A tracking phase precedes every conversion when tracking time is nonzero, after any power-up.
// - Without power-off mode the input tracks whenever not converting.
// - Resolution is 12 or 10 bits.
// - Cycle lasts any power-up ticks plus repeats times (track+bits+1) ticks plus 4 clocks.
// - External start may add synchroniser delay before the cycle.
// - Start by software busy write, internal event or external rising edge.
// - Only the first conversion of a sequence needs a trigger.
// - Done flag rises when all repeats are summed; result then readable.
// - Busy is high only during the conversion phase.
// - Autoscan writes words from up to four channels to memory in order.
// - Scan collects the programmed word count plus one words, at most 64.
// - Scan end saves state, raises the flag, restarts or leaves.
// - Single-trigger option lets one trigger run a whole scan.
// - Entering autoscan copies address, count, channels; waits for trigger.
// - At scan end: reload if enabled, else normal mode; the flag sets one cycle later.
// - Channels step circularly, each word's repeats on one channel.
module sarseq_top
	import sarseq_pkg::*;
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// configuration
	input  wire logic        converter_enable,
	input  wire logic        converter_clock_select,
	input  wire logic [4:0]  approximation_clock_divider,
	input  wire logic        power_off_after_conversion,
	input  wire logic [4:0]  power_up_time,
	input  wire logic [3:0]  tracking_time,
	input  wire logic        resolution_select,
	input  wire logic [1:0]  repeat_count,
	input  wire logic [1:0]  trigger_mode,
	input  wire logic [4:0]  input_channel_select,
	// autoscan configuration
	input  wire logic        autoscan_enable,
	input  wire logic        single_trigger_scan,
	input  wire logic [1:0]  scan_channel_count,
	input  wire logic [15:0] scan_start_address,
	input  wire logic [5:0]  scan_word_count,
	// triggers and flag clear
	input  wire logic        busy_write_one,
	input  wire logic        internal_trigger,
	input  wire logic        external_start_input,
	input  wire logic        done_flag_clear,
	// status and results
	output logic             conversion_busy,
	output logic             conversion_done_flag,
	output logic [7:0]       result_high,
	output logic [7:0]       result_low,
	output logic             clock_source_fast,
	output logic             divider_too_fast,
	output logic             autoscan_active,
	output logic [15:0]      scan_saved_address,
	output logic [4:0]       scan_saved_channel,
	// analog core
	output logic             converter_power_on,
	output logic             track_connect,
	output logic [4:0]       mux_channel,
	output logic [11:0]      sar_trial,
	input  wire logic        comparator_keep,
	// data memory write port
	output logic             mem_write_valid,
	output logic [15:0]      mem_write_address,
	output logic [15:0]      mem_write_data
);

	sarseq_link_if lnk ();

	sarseq_state_t state;
	logic [4:0]  phase_count;
	logic [4:0]  repeats_left;
	logic [11:0] trial_bit;
	logic [15:0] accum;
	logic [2:0]  tail_count;
	logic        ext_s1;
	logic        ext_s2;
	logic        ext_s3;
	logic        ext_level;
	logic        ext_rise;
	logic        trigger;
	logic        start;
	logic [4:0]  repeat_total;
	logic [11:0] msb;
	logic        word_valid;
	logic        tick;

	sarseq_divider u_divider (
		.mclk (mclk),
		.rst_n(rst_n),
		.lnk  (lnk)
	);

	sarseq_scanner u_scanner (
		.mclk (mclk),
		.rst_n(rst_n),
		.lnk  (lnk)
	);

	////////////////////////////////////////////////////////////////////////////
	// helper connections

	assign tick              = lnk.div_tick;
	assign lnk.div_ratio     = approximation_clock_divider;
	assign lnk.div_restart   = start;
	assign lnk.scan_enable   = autoscan_enable;
	assign lnk.conv_enable   = converter_enable;
	assign lnk.first_channel = input_channel_select;
	assign lnk.channel_count = scan_channel_count;
	assign lnk.start_address = scan_start_address;
	assign lnk.word_count    = scan_word_count;
	assign lnk.word_valid    = word_valid;
	assign lnk.word_data     = accum;

	// warns firmware the approximation clock is above its limit
	assign divider_too_fast = {1'b0, approximation_clock_divider} + 6'h01
		< SARSEQ_MIN_RATIO_W;

	always_comb
	begin
		unique case (repeat_count)
			2'h0: repeat_total = 5'h00;
			2'h1: repeat_total = 5'h03;
			2'h2: repeat_total = 5'h07;
			2'h3: repeat_total = 5'h0F;
		endcase
	end

	assign msb = (resolution_select == SARSEQ_RES_12) ? SARSEQ_MSB_12 : SARSEQ_MSB_10;

	////////////////////////////////////////////////////////////////////////////
	// clock source request, only changed between cycles

	// switching mid-cycle would stretch or chop an approximation period
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			clock_source_fast <= SARSEQ_CLKSEL_RESET;
		else if (state == SARSEQ_IDLE)
			clock_source_fast <= converter_clock_select;
	end

	////////////////////////////////////////////////////////////////////////////
	// external start synchroniser and trigger selection

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ext_s1    <= 1'b0;
			ext_s2    <= 1'b0;
			ext_s3    <= 1'b0;
			ext_level <= 1'b0;
		end
		else
		begin
			ext_s1 <= external_start_input;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
			if (ext_s2 == ext_s3)
				ext_level <= ext_s3;
		end
	end

	assign ext_rise = ext_s2 == ext_s3 && ext_s3 && !ext_level;

	always_comb
	begin
		unique case (trigger_mode)
			SARSEQ_TRIG_SOFTWARE: trigger = busy_write_one;
			SARSEQ_TRIG_INTERNAL: trigger = internal_trigger;
			SARSEQ_TRIG_EXTERNAL: trigger = ext_rise;
			default:              trigger = 1'b0;
		endcase
	end

	// in a single-trigger scan, words after the first start themselves
	assign start = state == SARSEQ_IDLE && converter_enable && !word_valid
		&& (trigger || (lnk.scan_running && single_trigger_scan));

	////////////////////////////////////////////////////////////////////////////
	// phase sequencer

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state       <= SARSEQ_IDLE;
			phase_count <= 5'h00;
			tail_count  <= 3'h0;
		end
		else if (!converter_enable)
			state <= SARSEQ_IDLE;
		else
		begin
			unique case (state)
				SARSEQ_IDLE:
					if (start)
					begin
						if (power_off_after_conversion && power_up_time != 5'h00)
						begin
							state       <= SARSEQ_POWER;
							phase_count <= power_up_time;
						end
						else if (tracking_time != 4'h0)
						begin
							state       <= SARSEQ_TRACK;
							phase_count <= {1'b0, tracking_time};
						end
						else
							state <= SARSEQ_CONVERT;
					end
				SARSEQ_POWER:
					if (tick && phase_count == 5'h01)
					begin
						state       <= (tracking_time != 4'h0) ? SARSEQ_TRACK
							: SARSEQ_CONVERT;
						phase_count <= {1'b0, tracking_time};
					end
					else if (tick)
						phase_count <= phase_count - 5'h01;
				SARSEQ_TRACK:
					if (tick && phase_count == 5'h01)
						state <= SARSEQ_CONVERT;
					else if (tick)
						phase_count <= phase_count - 5'h01;
				SARSEQ_CONVERT:
					// capture tick is the one after the last bit
					if (tick && trial_bit == 12'h000)
					begin
						if (repeats_left == 5'h00)
						begin
							state      <= SARSEQ_FINISH;
							tail_count <= SARSEQ_FINISH_CYCLES;
						end
						else if (tracking_time != 4'h0)
						begin
							state       <= SARSEQ_TRACK;
							phase_count <= {1'b0, tracking_time};
						end
					end
				SARSEQ_FINISH:
					if (tail_count == 3'h1)
						state <= SARSEQ_IDLE;
					else
						tail_count <= tail_count - 3'h1;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// approximation register and accumulator

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sar_trial    <= 12'h000;
			trial_bit    <= 12'h000;
			accum        <= SARSEQ_RESULT_RESET;
			repeats_left <= 5'h00;
		end
		else if (start)
		begin
			accum        <= 16'h0000;
			repeats_left <= repeat_total;
			sar_trial    <= msb;
			trial_bit    <= msb;
		end
		else if (state == SARSEQ_CONVERT && tick)
		begin
			if (trial_bit == 12'h000)
			begin
				accum        <= accum + {4'h0, sar_trial};
				repeats_left <= repeats_left - 5'h01;
				sar_trial    <= msb;
				trial_bit    <= msb;
			end
			else
			begin
				sar_trial <= (comparator_keep ? sar_trial : sar_trial & ~trial_bit)
					| (trial_bit >> 1);
				trial_bit <= trial_bit >> 1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// results, done flag and word hand-off

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			result_high <= 8'h00;
			result_low  <= 8'h00;
			word_valid  <= 1'b0;
		end
		else
		begin
			word_valid <= state == SARSEQ_FINISH && tail_count == 3'h1;
			if (state == SARSEQ_FINISH && tail_count == 3'h1)
			begin
				result_high <= accum[15:8];
				result_low  <= accum[7:0];
			end
		end
	end

	// a setting event beats a clear in the same cycle
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			conversion_done_flag <= 1'b0;
		else if ((word_valid && !lnk.scan_active) || lnk.scan_done)
			conversion_done_flag <= 1'b1;
		else if (done_flag_clear)
			conversion_done_flag <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// analog controls and scan outputs

	assign conversion_busy    = state == SARSEQ_CONVERT;
	assign converter_power_on = converter_enable
		&& (!power_off_after_conversion || state != SARSEQ_IDLE);
	assign track_connect      = converter_enable && (state == SARSEQ_TRACK
		|| (!power_off_after_conversion && state != SARSEQ_CONVERT));
	assign mux_channel        = lnk.scan_active ? lnk.scan_channel
		: input_channel_select;
	assign autoscan_active    = lnk.scan_active;
	assign scan_saved_address = lnk.saved_address;
	assign scan_saved_channel = lnk.saved_channel;
	assign mem_write_valid    = lnk.mem_valid;
	assign mem_write_address  = lnk.mem_address;
	assign mem_write_data     = lnk.mem_data;

endmodule
`default_nettype wire

// File: dv/sarseq_core_model.sv
// Purpose: analog core model, one ideal comparator per input channel
// Assumes: the bench loads level[] before the first trigger
// Notes:   no noise, so every conversion of a channel gives its level
`timescale 1ns/1ps
`default_nettype none
module sarseq_core_model
(
	// from the sequencer
	input  wire logic [4:0]  mux_channel,
	input  wire logic [11:0] sar_trial,
	input  wire logic        converter_power_on,
	// to the sequencer
	output logic             comparator_keep
);
	logic [11:0] level [32];
	// unpowered core gives a changing answer, never a stale decision
	assign comparator_keep = converter_power_on ? (sar_trial <= level[mux_channel]) : ^sar_trial;
endmodule
`default_nettype wire

// File: dv/sarseq_chk.sv
// Purpose: port-level checks of the converter sequencer
// Assumes: single clock domain on mclk
// Notes:   bound to every sarseq_top instance
`timescale 1ns/1ps
`default_nettype none
module sarseq_chk
	import sarseq_pkg::*;
(
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_n,
	// configuration
	input  wire logic       converter_enable,
	input  wire logic       power_off_after_conversion,
	input  wire logic [4:0] approximation_clock_divider,
	input  wire logic [3:0] tracking_time,
	// status and analog side
	input  wire logic       conversion_busy,
	input  wire logic       conversion_done_flag,
	input  wire logic [7:0] result_high,
	input  wire logic [7:0] result_low,
	input  wire logic       divider_too_fast,
	input  wire logic       converter_power_on,
	input  wire logic       track_connect,
	input  wire logic       mem_write_valid
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////////////
	a_busy_no_track: assert property (conversion_busy |-> !track_connect)
		else $error("input still connected while converting");
	a_busy_powered: assert property (conversion_busy |-> converter_power_on)
		else $error("converting while powered down");
	a_stay_powered: assert property (
		converter_enable && !power_off_after_conversion |-> converter_power_on)
		else $error("converter dropped power without power-off mode");
	a_track_first: assert property (
		$rose(conversion_busy) && tracking_time != 4'h0 |-> $past(track_connect))
		else $error("conversion began without tracking");
	a_result_hold: assert property (
		conversion_busy |=> $stable(result_high) && $stable(result_low))
		else $error("result changed during conversion");
	a_done_idle: assert property ($rose(conversion_done_flag) |-> !conversion_busy)
		else $error("done flag rose while busy");
	a_divider_limit: assert property (
		divider_too_fast == (approximation_clock_divider < 5'(SARSEQ_MIN_RATIO - 1)))
		else $error("divider limit flag wrong");
	a_write_pulse: assert property (mem_write_valid |=> !mem_write_valid)
		else $error("memory write held longer than one cycle");
	c_repeat: cover property ($rose(conversion_busy) ##[1:400] $rose(conversion_busy));
	c_power: cover property (power_off_after_conversion && $rose(conversion_busy));
	c_scan: cover property (mem_write_valid ##[1:100] conversion_done_flag);
endmodule
bind sarseq_top sarseq_chk sarseq_chk_i (.*);
`default_nettype wire

// File: dv/sarseq_top_tb.sv
// Purpose: self-checking bench of the converter sequencer
// Assumes: analog core is the ideal comparator model
// Notes:   cycle counts run from the edge that takes the trigger
`timescale 1ns/1ps
`default_nettype none
module sarseq_top_tb
	import sarseq_pkg::*;
;
	logic        mclk = 1'b0, rst_n = 1'b0, converter_enable = 1'b1;
	logic        converter_clock_select = 1'b0, power_off_after_conversion = 1'b0;
	logic [4:0]  approximation_clock_divider = 5'h00, power_up_time = 5'h00;
	logic [4:0]  input_channel_select = 5'h00, scan_saved_channel, mux_channel;
	logic [3:0]  tracking_time = 4'h1;
	logic [1:0]  repeat_count = 2'h0, trigger_mode = 2'h0, scan_channel_count = 2'h0;
	logic        resolution_select = 1'b1, autoscan_enable = 1'b0, single_trigger_scan = 1'b0;
	logic [15:0] scan_start_address = 16'h0000, scan_saved_address;
	logic [5:0]  scan_word_count = 6'h00;
	logic        busy_write_one = 1'b0, internal_trigger = 1'b0;
	logic        external_start_input = 1'b0, done_flag_clear = 1'b0;
	logic        conversion_busy, conversion_done_flag, clock_source_fast, divider_too_fast;
	logic        autoscan_active, converter_power_on, track_connect, comparator_keep;
	logic        mem_write_valid;
	logic [7:0]  result_high, result_low;
	logic [11:0] sar_trial;
	logic [15:0] mem_write_address, mem_write_data;
	logic [15:0] wa[$], wd[$];
	int          num_errors = 0, compares = 0;

	sarseq_top sarseq_top_i (.*);
	sarseq_core_model sarseq_core_model_i (.*);

	always #5 mclk = ~mclk;
	always @(posedge mclk)
		if (mem_write_valid === 1'b1)
		begin
			wa.push_back(mem_write_address);
			wd.push_back(mem_write_data);
		end
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [11:0] lvl(input int ch);
		return 12'h123 + 12'(ch) * 12'h0B5;
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR %0t %s: got %0h expected %0h", $time, what, got, exp);
		end
	endtask

	task automatic check_near(input int got, input int exp, input int slack, input string what);
		compares++;
		if (got < exp - slack || got > exp + slack)
		begin
			num_errors++;
			$display("ERROR %0t %s: got %0d expected %0d", $time, what, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// the pin stays up until the next call: the synchroniser drops one-cycle pulses
	task automatic fire(input int m);
		@(posedge mclk);
		done_flag_clear <= 1'b1;
		busy_write_one <= (m == 0);
		internal_trigger <= (m == 1);
		external_start_input <= (m == 2);
		@(posedge mclk);
		done_flag_clear <= 1'b0;
		busy_write_one <= 1'b0;
		internal_trigger <= 1'b0;
		#1;
	endtask

	task automatic wait_done(output int cyc, output int rises);
		logic prev;
		cyc = 0;
		rises = 0;
		prev = 1'b0;
		while (conversion_done_flag !== 1'b1 && cyc < 3000)
		begin
			@(posedge mclk);
			#1;
			cyc++;
			if (conversion_busy === 1'b1 && !prev)
				rises++;
			prev = conversion_busy;
		end
	endtask

	task automatic conv(input int m, input int ecyc, input int slack, input logic [15:0] eres,
		input int erise);
		int cyc, rises;
		fire(m);
		wait_done(cyc, rises);
		check_near(cyc, ecyc, slack, "cycle length");
		check({result_high, result_low}, eres, "result");
		check(rises, erise, "conversion phases");
	endtask

	task automatic cfg(input logic [4:0] n, input logic pwr, input logic [3:0] trk,
		input logic res, input logic [1:0] rpt, input logic [4:0] ch);
		@(posedge mclk);
		approximation_clock_divider <= n;
		power_off_after_conversion <= pwr;
		tracking_time <= trk;
		resolution_select <= res;
		repeat_count <= rpt;
		input_channel_select <= ch;
		trigger_mode <= SARSEQ_TRIG_SOFTWARE;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		tick(2);
		check({result_high, result_low}, SARSEQ_RESULT_RESET, "reset result");
		check(clock_source_fast, SARSEQ_CLKSEL_RESET, "reset clock source");
		check(converter_power_on, 1'b1, "powered without power-off mode");
		$display("t_reset done");
	endtask

	task automatic t_accumulate();
		int r;
		int reps[4];
		reps = '{1, 4, 8, 16};
		for (r = 0; r < 4; r++)
		begin
			cfg(5'h00, 1'b0, 4'h1, 1'b1, 2'(r), 5'h14);
			conv(0, reps[r] * 14 + 5, 0, 16'(reps[r] * 32'hF47), reps[r]);
		end
		cfg(5'h00, 1'b0, 4'h1, 1'b0, 2'h1, 5'h00);
		conv(0, 53, 0, 16'h048C, 4);
		$display("t_accumulate done");
	endtask

	task automatic t_power_off();
		cfg(5'h00, 1'b1, 4'h2, 1'b1, 2'h1, 5'h03);
		power_up_time <= 5'h03;
		tick(1);
		check(converter_power_on, 1'b0, "off before trigger");
		conv(0, 68, 0, 16'h0D08, 4);
		check(converter_power_on, 1'b0, "off after sequence");
		$display("t_power_off done");
	endtask

	task automatic t_triggers();
		int m, k;
		cfg(5'h00, 1'b0, 4'h1, 1'b1, 2'h0, 5'h04);
		for (m = 0; m < 4; m++)
		begin
			@(posedge mclk);
			trigger_mode <= 2'(m);
			for (k = 0; k < 3; k++)
				if (k != m)
					fire(k);
			tick(40);
			check(conversion_done_flag, 1'b0, "foreign trigger ignored");
			if (m < 3)
				conv(m, (m == 2) ? 22 : 19, (m == 2) ? 2 : 0, 16'h03F7, 1);
		end
		$display("t_triggers done");
	endtask

	task automatic t_divider();
		@(posedge mclk);
		approximation_clock_divider <= 5'h04;
		converter_clock_select <= 1'b1;
		tick(2);
		check(divider_too_fast, 1'b1, "ratio 5 too fast");
		check(clock_source_fast, 1'b1, "fast source taken");
		cfg(5'h05, 1'b0, 4'h1, 1'b1, 2'h0, 5'h14);
		tick(1);
		check(divider_too_fast, 1'b0, "ratio 6 allowed");
		conv(0, 89, 0, 16'h0F47, 1);
		$display("t_divider done");
	endtask

	task automatic t_scan(input logic one);
		int cyc, rises, nw, i;
		nw = one ? 4 : 2;
		wa.delete();
		wd.delete();
		cfg(5'h00, 1'b0, 4'h1, 1'b1, 2'h0, 5'h03);
		scan_channel_count <= one ? 2'h1 : 2'h0;
		scan_word_count <= 6'(nw - 1);
		scan_start_address <= 16'h0101;
		single_trigger_scan <= one;
		autoscan_enable <= 1'b1;
		@(posedge mclk);
		autoscan_enable <= !one;
		scan_start_address <= 16'h0F00;
		tick(2);
		check(autoscan_active, 1'b1, "scan armed");
		fire(0);
		if (!one)
		begin
			tick(80);
			check(wa.size(), 1, "one word per trigger");
			fire(0);
		end
		wait_done(cyc, rises);
		check(wa.size(), nw, "word count");
		for (i = 0; i < nw; i++)
		begin
			check(wa[i], 16'h0100 + 16'(2 * i), "word address");
			check(wd[i], {4'h0, lvl(one ? 3 + i % 2 : 3)}, "word data");
		end
		check(autoscan_active, !one, "scan end");
		if (one)
		begin
			check(scan_saved_address, 16'h0108, "saved address");
			check(scan_saved_channel, 5'h04, "saved channel");
		end
		@(posedge mclk);
		converter_enable <= 1'b0;
		autoscan_enable <= 1'b0;
		tick(2);
		check(autoscan_active, 1'b0, "disable leaves scan");
		@(posedge mclk);
		converter_enable <= 1'b1;
		$display("t_scan done");
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		for (int i = 0; i < 32; i++)
			sarseq_core_model_i.level[i] = lvl(i);
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		t_reset();
		t_accumulate();
		t_power_off();
		t_triggers();
		t_divider();
		t_scan(1'b1);
		t_scan(1'b0);
		complete_run();
	end

	// the tests need about 1200 cycles; a hang stops well past that
	initial
	begin
		repeat (10000) @(posedge mclk);
		num_errors++;
		$display("ERROR %0t watchdog expired", $time);
		complete_run();
	end
endmodule
`default_nettype wire
